// File: tcw_pkg.sv
// Constants and types shared by the compare-output waveform block
package tcw_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0]  TCW_OFS_CTRL_A = 4'h0;  // Channel A control
    localparam logic [3:0]  TCW_OFS_CTRL_B = 4'h4;  // Channel B control
    localparam logic [3:0]  TCW_OFS_STATUS = 4'h8;  // Output state, read only

    // Control register field positions
    localparam int          TCW_CAP_BIT    = 0;     // Capture select
    localparam int          TCW_INV_BIT    = 1;     // Polarity invert
    localparam int          TCW_MODE_LSB   = 2;     // Generation mode, 3 bits
    localparam int          TCW_LVL_BIT    = 5;     // Software level
    localparam int          TCW_PAIR_BIT   = 6;     // Pair match use

    // Reset value and writable bits of a control register
    localparam logic [15:0] TCW_CTRL_RST   = 16'h0000;
    localparam logic [15:0] TCW_CTRL_MASK  = 16'h007F;

    // Reset values of the bus answer and output flops
    localparam logic        TCW_WAIT_RST   = 1'b1;
    localparam logic        TCW_WAVE_RST   = 1'b0;

    // Generation modes, codes 0 to 7 in declaration order
    typedef enum logic [2:0] {
        TCW_MODE_SW,        // Software level
        TCW_MODE_SET,       // Set only
        TCW_MODE_TOG_RST,   // Toggle, then reset
        TCW_MODE_SET_RST,   // Set, then reset
        TCW_MODE_TOG,       // Toggle only
        TCW_MODE_RST,       // Reset only
        TCW_MODE_TOG_SET,   // Toggle, then set
        TCW_MODE_RST_SET    // Reset, then set
    } tcw_mode_t;

    // Counter direction as reported by the counter
    typedef enum logic [1:0] {
        TCW_CNT_UP,
        TCW_CNT_DOWN,
        TCW_CNT_UPDOWN,
        TCW_CNT_RSVD
    } tcw_cnt_t;

endpackage

// File: tcw_wave_engine.sv
// One channel's output waveform engine with polarity stage
`timescale 1ns/1ns
module tcw_wave_engine
(
    input  wire logic       clk_in,             // Timer clock
    input  wire logic       rst_n_in,           // Asynchronous reset
    input  wire logic [2:0] mode_in,            // Generation mode
    input  wire logic       capture_in,         // Channel in capture use
    input  wire logic       invert_in,          // Active low when set
    input  wire logic       sw_level_in,        // Software pin level
    input  wire logic       pair_use_in,        // Use partner match
    input  wire logic       own_match_in,       // Own compare match pulse
    input  wire logic       partner_match_in,   // Partner compare match pulse
    input  wire logic       period_evt_in,      // MAX or ZERO, chosen above
    output logic            active_out,         // Internal active state
    output logic            pin_out             // Pin level, registered
);

    logic active_reg;   // Active state of the waveform
    logic active_next;  // Next active state
    logic pin_reg;      // Registered pin level
    logic pin_next;     // Next pin level
    logic set_evt;      // Drive active this cycle
    logic clr_evt;      // Drive inactive this cycle
    logic tog_evt;      // Invert this cycle
    logic other_evt;    // Partner match or period event
    logic any_match;    // Own match, or either match of the pair with pair use

    // Decode the events that move the waveform for the chosen mode
    always_comb
    begin
        other_evt = pair_use_in ? partner_match_in : period_evt_in;
        any_match = own_match_in | (pair_use_in & partner_match_in);
        set_evt   = 1'b0;
        clr_evt   = 1'b0;
        tog_evt   = 1'b0;
        unique case (tcw_pkg::tcw_mode_t'(mode_in))
            tcw_pkg::TCW_MODE_RST_SET:
            begin
                clr_evt = own_match_in;
                set_evt = other_evt;
            end
            tcw_pkg::TCW_MODE_TOG_SET:
            begin
                tog_evt = own_match_in;
                set_evt = other_evt;
            end
            tcw_pkg::TCW_MODE_RST:     clr_evt = any_match;
            tcw_pkg::TCW_MODE_TOG:     tog_evt = any_match;
            tcw_pkg::TCW_MODE_SET_RST:
            begin
                set_evt = own_match_in;
                clr_evt = other_evt;
            end
            tcw_pkg::TCW_MODE_TOG_RST:
            begin
                tog_evt = own_match_in;
                clr_evt = other_evt;
            end
            tcw_pkg::TCW_MODE_SET:     set_evt = any_match;
            tcw_pkg::TCW_MODE_SW:      set_evt = 1'b0;
        endcase
    end

    // Next state: set and reset beat a toggle in the same cycle; where
    // set and reset meet, the event closing the period decides
    always_comb
    begin
        active_next = active_reg;
        pin_next    = pin_reg;
        if (!capture_in)
        begin
            if (mode_in == 3'(tcw_pkg::TCW_MODE_SW))
            begin
                // Software level is a pin level, not an active state
                pin_next    = sw_level_in;
                active_next = sw_level_in ^ invert_in;
            end
            else
            begin
                if (set_evt && clr_evt)
                    active_next = (mode_in == 3'(tcw_pkg::TCW_MODE_RST_SET));
                else if (set_evt)
                    active_next = 1'b1;
                else if (clr_evt)
                    active_next = 1'b0;
                else if (tog_evt)
                    active_next = ~active_reg;
                pin_next = active_next ^ invert_in;
            end
        end
    end

    // State and pin flops; capture use freezes both
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            active_reg <= tcw_pkg::TCW_WAVE_RST;
            pin_reg    <= tcw_pkg::TCW_WAVE_RST;
        end
        else
        begin
            active_reg <= active_next;
            pin_reg    <= pin_next;
        end
    end

    assign active_out = active_reg;
    assign pin_out    = pin_reg;

endmodule // tcw_wave_engine

// File: tcw_compare_output.sv
// Compare-output waveform block for one comparator pair, Avalon-MM slave
`timescale 1ns/1ns

// Contract
// - Mode and level bits ignored in capture
// - Mode zero: output follows software level bit
// - Software level zero gives low pin
// - Mode 7: match resets, MAX/ZERO/partner sets
// - Mode 6: match toggles, MAX/ZERO/partner sets
// - Mode 5: matches only reset the output
// - Mode 4: matches only toggle the output
// - Mode 3: match sets, MAX/ZERO/partner resets
// - Mode 2: match toggles, MAX/ZERO/partner resets
// - Mode 1: matches only set the output
// - Software level one gives high pin
// - Pair bit selects partner match over MAX/ZERO
// - Polarity bit maps active to pin level
// - Channel mode bit: zero compare, one capture
module tcw_compare_output
#(
    parameter int ADDR_W = 4    // Byte address width of the slave
)
(
    input  wire logic              clk_in,               // Timer clock
    input  wire logic              rst_n_in,             // Asynchronous reset
    input  wire logic [ADDR_W-1:0] avs_address_in,       // Byte address
    input  wire logic              avs_read_in,          // Read request
    input  wire logic              avs_write_in,         // Write request
    input  wire logic [31:0]       avs_writedata_in,     // Write data
    input  wire logic [3:0]        avs_byteenable_in,    // Byte lanes
    output logic      [31:0]       avs_readdata_out,     // Read data
    output logic                   avs_waitrequest_out,  // Stall
    input  wire logic              match_a_in,           // Channel A match
    input  wire logic              match_b_in,           // Channel B match
    input  wire logic              cnt_max_in,           // Counter MAX
    input  wire logic              cnt_zero_in,          // Counter ZERO
    input  wire logic [1:0]        count_mode_in,        // Counter direction
    output logic      [1:0]        channel_wave_out      // Output pins
);

    // Elaboration check: offsets need at least four address bits
    if (ADDR_W < 4)
    begin : g_addr_check
        $error("ADDR_W must be at least 4");
    end

    // Control registers of the two channels
    logic [15:0]       ctrl_a_reg;      // Channel A control
    logic [15:0]       ctrl_b_reg;      // Channel B control

    // Bus answer flops
    logic              wait_reg;        // Waitrequest, high when idle
    logic [31:0]       rdata_reg;       // Read data held for the answer
    logic [31:0]       rdata_next;      // Read data of the current address

    // Bus request decode
    logic              req;             // Read or write present
    logic              wr_take;         // Write takes effect this edge
    logic              hit_a;           // Address selects channel A
    logic              hit_b;           // Address selects channel B
    logic              hit_s;           // Address selects status

    // Waveform engine outputs
    logic              active_a;        // Channel A active state
    logic              active_b;        // Channel B active state
    logic              pin_a;           // Channel A pin level
    logic              pin_b;           // Channel B pin level

    // Period event chosen from counter direction
    logic              period_evt;      // MAX or ZERO for this direction

    // Address decode shared by every register select
    function automatic logic addr_is
    (
        input logic [ADDR_W-1:0] addr,
        input logic [3:0]        ofs
    );
        addr_is = (addr == ADDR_W'(ofs));
    endfunction

    // Byte lane merge of a 16-bit control register; only
    // the writable bits change, reserved bits stay zero
    function automatic logic [15:0] merge_ctrl
    (
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] merged;
        merged = old_val;
        if (be[0])
        begin
            merged[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            merged[15:8] = wdata[15:8];
        end
        merge_ctrl = merged & tcw_pkg::TCW_CTRL_MASK;
    endfunction

    // Request decode
    always_comb
    begin
        req     = avs_read_in | avs_write_in;
        hit_a   = addr_is(avs_address_in, tcw_pkg::TCW_OFS_CTRL_A);
        hit_b   = addr_is(avs_address_in, tcw_pkg::TCW_OFS_CTRL_B);
        hit_s   = addr_is(avs_address_in, tcw_pkg::TCW_OFS_STATUS);
        // The write lands on the edge where the master sees
        // waitrequest low, and on that edge only
        wr_take = avs_write_in & ~wait_reg;
    end

    // Waitrequest drops for one cycle after a request is seen,
    // then rises again; every access costs exactly one stall cycle.
    // A flop-driven answer keeps the bus output glitch free.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_reg <= tcw_pkg::TCW_WAIT_RST;
        end
        else if (req && wait_reg)
        begin
            // Answer on the next cycle
            wait_reg <= 1'b0;
        end
        else
        begin
            // Back to stall once the answer was given
            wait_reg <= 1'b1;
        end
    end

    // Read mux; an unmapped address reads as zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (hit_a)
        begin
            rdata_next[15:0] = ctrl_a_reg;
        end
        else if (hit_b)
        begin
            rdata_next[15:0] = ctrl_b_reg;
        end
        else if (hit_s)
        begin
            // Pin levels in bits 1:0, active states in bits 3:2
            rdata_next[3:0] = {active_b, active_a, pin_b, pin_a};
        end
        else
        begin
            // Unmapped: zero
            rdata_next = 32'h0000_0000;
        end
    end

    // Read data is loaded while waitrequest is still high so it
    // already stands in the cycle the master samples it
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (avs_read_in && wait_reg)
        begin
            rdata_reg <= rdata_next;
        end
        else if (!wait_reg)
        begin
            // Clear after the answer so stale data never lingers
            rdata_reg <= 32'h0000_0000;
        end
    end

    // Channel A control register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_a_reg <= tcw_pkg::TCW_CTRL_RST;
        end
        else if (wr_take && hit_a)
        begin
            // Reserved bits are masked off in the merge
            ctrl_a_reg <= merge_ctrl(ctrl_a_reg, avs_writedata_in, avs_byteenable_in);
        end
    end

    // Channel B control register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_b_reg <= tcw_pkg::TCW_CTRL_RST;
        end
        else if (wr_take && hit_b)
        begin
            // Writes to the status offset are ignored
            ctrl_b_reg <= merge_ctrl(ctrl_b_reg, avs_writedata_in, avs_byteenable_in);
        end
    end

    // The counter reports its direction; down counting ends a
    // period at ZERO, up and up/down counting at MAX. The
    // reserved code is treated as up counting.
    always_comb
    begin
        unique case (tcw_pkg::tcw_cnt_t'(count_mode_in))
            tcw_pkg::TCW_CNT_DOWN:
            begin
                period_evt = cnt_zero_in;
            end
            tcw_pkg::TCW_CNT_UP,
            tcw_pkg::TCW_CNT_UPDOWN,
            tcw_pkg::TCW_CNT_RSVD:
            begin
                period_evt = cnt_max_in;
            end
        endcase
    end

    // Channel A waveform: own match A, partner match B.
    // Events come from logic on this clock, so no synchroniser.
    tcw_wave_engine u_wave_a
    (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .mode_in          (ctrl_a_reg[tcw_pkg::TCW_MODE_LSB +: 3]),
        .capture_in       (ctrl_a_reg[tcw_pkg::TCW_CAP_BIT]),
        .invert_in        (ctrl_a_reg[tcw_pkg::TCW_INV_BIT]),
        .sw_level_in      (ctrl_a_reg[tcw_pkg::TCW_LVL_BIT]),
        .pair_use_in      (ctrl_a_reg[tcw_pkg::TCW_PAIR_BIT]),
        .own_match_in     (match_a_in),
        .partner_match_in (match_b_in),
        .period_evt_in    (period_evt),
        .active_out       (active_a),
        .pin_out          (pin_a)
    );

    // Channel B waveform: roles of the two matches swapped,
    // which gives the complementary pair behaviour
    tcw_wave_engine u_wave_b
    (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .mode_in          (ctrl_b_reg[tcw_pkg::TCW_MODE_LSB +: 3]),
        .capture_in       (ctrl_b_reg[tcw_pkg::TCW_CAP_BIT]),
        .invert_in        (ctrl_b_reg[tcw_pkg::TCW_INV_BIT]),
        .sw_level_in      (ctrl_b_reg[tcw_pkg::TCW_LVL_BIT]),
        .pair_use_in      (ctrl_b_reg[tcw_pkg::TCW_PAIR_BIT]),
        .own_match_in     (match_b_in),
        .partner_match_in (match_a_in),
        .period_evt_in    (period_evt),
        .active_out       (active_b),
        .pin_out          (pin_b)
    );

    // Outputs; both pins come straight from the engine flops
    assign avs_waitrequest_out = wait_reg;
    assign avs_readdata_out    = rdata_reg;
    assign channel_wave_out    = {pin_b, pin_a};

endmodule // tcw_compare_output

// File: tcw_chk_sva.sv
// Concurrent checks on the ports of the compare-output waveform block
`timescale 1ns/1ns
module tcw_chk
#(
    parameter int ADDR_W = 4    // Byte address width, handed on by the bind
)
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic [31:0]       avs_readdata_out,
    input  wire logic              avs_waitrequest_out,
    input  wire logic              match_a_in,
    input  wire logic              match_b_in,
    input  wire logic              cnt_max_in,
    input  wire logic              cnt_zero_in,
    input  wire logic [1:0]        count_mode_in,
    input  wire logic [1:0]        channel_wave_out
);
    logic [6:0] sha;    // Shadow of channel A control, rebuilt from bus writes
    logic [2:0] md;     // Shadow generation mode
    logic       on;     // Compare use with normal polarity
    logic       pa;     // Channel A pin
    assign md = sha[4:2];
    assign on = !sha[0] && !sha[1];
    assign pa = channel_wave_out[0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow moves at the completing edge, as the real register does
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
            sha <= 7'h00;
        else if (avs_write_in && !avs_waitrequest_out && avs_address_in == '0 && avs_byteenable_in[0])
            sha <= avs_writedata_in[6:0];
    property p_sw_high; (md == 3'h0 && !sha[0] && sha[5]) |=> pa; endproperty
    a_sw_high: assert property (p_sw_high) else $error("pin A not high");
    property p_sw_low; (md == 3'h0 && !sha[0] && !sha[5]) |=> !pa; endproperty
    a_sw_low: assert property (p_sw_low) else $error("pin A not low");
    property p_frozen; sha[0] |=> $stable(pa); endproperty
    a_frozen: assert property (p_frozen) else $error("pin A moved in capture");
    property p_set_only; (on && md == 3'h1 && match_a_in) |=> pa; endproperty
    a_set_only: assert property (p_set_only) else $error("set missed");
    property p_rst_pair; (on && md == 3'h5 && sha[6] && match_b_in) |=> !pa; endproperty
    a_rst_pair: assert property (p_rst_pair) else $error("pair reset missed");
    property p_toggle;
        (on && md == 3'h4 && !sha[6] && match_a_in && $stable(sha)) |=> pa != $past(pa);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");
    property p_polarity; (!sha[0] && sha[1] && md == 3'h1 && match_a_in) |=> !pa; endproperty
    a_polarity: assert property (p_polarity) else $error("inverted set wrong");
    property p_max_wins;
        (on && md == 3'h3 && !sha[6] && cnt_max_in && count_mode_in != 2'h1) |=> !pa;
    endproperty
    a_max_wins: assert property (p_max_wins) else $error("MAX reset missed");
    property p_rst_set; (on && md == 3'h7 && sha[6] && match_b_in) |=> pa; endproperty
    a_rst_set: assert property (p_rst_set) else $error("partner set missed");
    property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_taken; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_taken: assert property (p_taken) else $error("request not answered");
    property p_rd_idle; avs_waitrequest_out |-> avs_readdata_out == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
endmodule // tcw_chk

// File: tcw_pin_load.sv
// Load model on the output pins: counts rising edges seen on pin A
`timescale 1ns/1ns
module tcw_pin_load
(
    input  wire logic        clk_in,     // Timer clock
    input  wire logic        rst_n_in,   // Reset, active low
    input  wire logic [1:0]  pin_in,     // Pins as driven by the block
    output logic      [15:0] rises_out   // Rising edges of pin A
);
    logic pin_a_reg;    // Last level seen; a passive load never drives back
    // Edge counter, sampled on the timer clock like a synchronous observer
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            pin_a_reg <= 1'h0;
            rises_out <= 16'h0000;
        end
        else
        begin
            pin_a_reg <= pin_in[0];
            if (pin_in[0] && !pin_a_reg)
                rises_out <= rises_out + 16'h0001;
        end
endmodule // tcw_pin_load

// File: tb_top.sv
// Self-checking bench for the compare-output waveform block
`timescale 1ns/1ns
module tb_top;
    logic        clk_in = 1'h0;     // 250 MHz timer clock
    logic        rst_n_in = 1'h0;   // Held low for two cycles
    logic [3:0]  addr = 4'h0, be = 4'h0;
    logic        rd = 1'h0, wr = 1'h0, wt;
    logic [31:0] wdata = 32'h0, rdata;
    logic        ma = 1'h0, mb = 1'h0, cmax = 1'h0, czero = 1'h0;
    logic [1:0]  cmode = 2'h0, pins;
    logic [15:0] rises;             // Edge count from the load model
    logic [6:0]  mctl [2] = '{7'h00, 7'h00}; // Model control per channel
    int          mact [2], mpin [2], mrise = 0, mprev = 0;
    bit          ev_en = 1'h0;      // Random events only outside bus work
    int          mismatches = 0, n_tests = 0;
    always #2 clk_in = ~clk_in;
    tcw_compare_output DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
        .match_a_in(ma), .match_b_in(mb), .cnt_max_in(cmax), .cnt_zero_in(czero),
        .count_mode_in(cmode), .channel_wave_out(pins));
    tcw_pin_load LOAD (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(pins), .rises_out(rises));
    task automatic chk_pin(input string nm, input int exp, input logic got);
        n_tests++;
        if (got !== 1'(exp))
        begin
            $display("[ERR] %s expected %0d seen %b", nm, exp, got);
            mismatches++;
        end
    endtask
    task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Next active state of one channel, from the control held before the edge
    function automatic int nxt(int c);
        int own, par, per, s, r, t, m, a;
        own = c ? mb : ma;
        par = c ? ma : mb;
        per = mctl[c][6] ? par : ((cmode == 2'h1) ? czero : cmax);
        m = mctl[c][4:2];
        a = mact[c];
        s = (m == 1 || m == 5) ? 0 : 0;
        r = 0;
        t = 0;
        if (m == 0) return mctl[c][5] ^ mctl[c][1];
        if (m == 1) s = own | (mctl[c][6] & par);
        if (m == 5) r = own | (mctl[c][6] & par);
        if (m == 4) t = own | (mctl[c][6] & par);
        if (m == 2 || m == 6) t = own;
        if (m == 3) s = own;
        if (m == 7) r = own;
        if (m == 6 || m == 7) s = s | per;
        if (m == 2 || m == 3) r = r | per;
        if (m == 3 && r) return 0;                        // Period event wins
        if (s) return 1;
        if (r) return 0;
        return t ? !a : a;
    endfunction
    // Reference model; capture use freezes state and pin
    always @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            mact <= '{0, 0};
            mpin <= '{0, 0};
        end
        else
            for (int c = 0; c < 2; c++)
                if (!mctl[c][0])
                begin
                    mact[c] <= nxt(c);
                    mpin[c] <= (mctl[c][4:2] == 3'h0) ? int'(mctl[c][5]) : nxt(c) ^ mctl[c][1];
                end
    // Random event pulses from the counter and both comparators
    always @(posedge clk_in)
    begin
        ma <= ev_en & ($urandom % 4 == 0);
        mb <= ev_en & ($urandom % 4 == 0);
        cmax <= ev_en & ($urandom % 6 == 0);
        czero <= ev_en & ($urandom % 6 == 0);
    end
    // Pins compared with the model every cycle, away from the launching edge
    always @(negedge clk_in)
        if (rst_n_in)
        begin
            chk_pin("pin_a", mpin[0], pins[0]);
            chk_pin("pin_b", mpin[1], pins[1]);
            mrise += (mpin[0] && !mprev);
            mprev = mpin[0];
        end
    // One bus access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        be <= b;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wt !== 1'h0 && n < 50);
        if (n >= 50)
        begin
            mismatches++;
            conclude();
        end
        q = rdata;
        if (w && b[0] && (a == 4'h0 || a == 4'h4))
            mctl[a[2]] <= d[6:0];
        wr <= 1'h0;
        rd <= 1'h0;
    endtask
    // Main sequence: every mode, pair use, polarity and count mode on channel A
    initial
    begin
        logic [31:0] q, d, st;
        void'($urandom(78));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        for (int i = 0; i < 128; i++)
        begin
            d = $urandom();
            d[6:0] = {i[3], d[5], i[2:0], i[4], 1'($urandom % 5 == 0)};
            bus(1'h1, 4'h0, d, 4'hF, q);
            bus(1'h1, 4'h4, $urandom(), 4'hF, q);
            cmode <= i[6:5];
            bus(1'h0, 4'h0, 32'h0, 4'hF, q);
            chk_reg("ctrl_a", d & 32'h0000_007F, q);
            bus(1'h0, 4'h4, 32'h0, 4'hF, q);
            chk_reg("ctrl_b", {25'h0, mctl[1]}, q);
            ev_en <= 1'h1;
            repeat (24) @(posedge clk_in);
            ev_en <= 1'h0;
            repeat (2) @(posedge clk_in);
            bus(1'h0, 4'h8, 32'h0, 4'hF, q);
            st = (mact[1] << 3) | (mact[0] << 2) | (mpin[1] << 1) | mpin[0];
            chk_reg("status", st, q);
        end
        bus(1'h1, 4'h8, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'h1, 4'h0, 32'h0000_007F, 4'hE, q);
        bus(1'h0, 4'h0, 32'h0, 4'hF, q);
        chk_reg("ctrl_a_lanes", {25'h0, mctl[0]}, q);
        bus(1'h0, 4'h8, 32'h0, 4'hF, q);
        chk_reg("status_ro", st, q);
        bus(1'h0, 4'hC, 32'h0, 4'hF, q);
        chk_reg("unmapped", 32'h0000_0000, q);
        chk_reg("rises", 32'(mrise), {16'h0, rises});
        conclude();
    end
    // Watchdog: about eight times the expected run length
    initial
    begin
        #(4 * 40000);
        mismatches++;
        conclude();
    end
endmodule // tb_top
bind tcw_compare_output tcw_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .match_a_in(match_a_in), .match_b_in(match_b_in), .cnt_max_in(cnt_max_in),
    .cnt_zero_in(cnt_zero_in), .count_mode_in(count_mode_in),
    .channel_wave_out(channel_wave_out));
